/* inc/gcgp_pkg.sv */
package gcgp_pkg;
    // ********************************************
    // Register map
    // ********************************************
    // Device configuration space: 32-bit words, byte lanes by byte enable
    localparam logic [7:0] ADDR_CFG_W0 = 8'h8c;
    localparam logic [7:0] ADDR_CFG_W1 = 8'h90;
    localparam logic [7:0] ADDR_PIN_LO = 8'h93;
    localparam logic [7:0] ADDR_PIN_HI = 8'h99;
    localparam int REVISION_LSB = 0;
    localparam int CTRL_LSB = 16;
    localparam logic [7:0] REVISION_VALUE = 8'h10; // Arbitrary value
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] DIR_RESET = 8'hff;
    localparam logic [7:0] ZERO_RESET = 8'h00;
    localparam int PINS = 8;
    localparam int GROUPS = 2;
    // Field positions inside the global control byte
    localparam int CB_BCAST = 0;
    localparam int CB_WAKEOFF = 1;
    localparam int CB_IRQOFF = 2;
    localparam int CB_LOADERR = 3;
    localparam int CB_ECLK = 4;
    localparam int CB_ECS = 5;
    localparam int CB_EDI = 6;
    localparam int CB_EDO = 7;
    // Index of each register inside a pin group
    typedef enum logic [2:0] {
        PR_INTEN = 3'h0,
        PR_LEVEL = 3'h1,
        PR_TRI = 3'h2,
        PR_INV = 3'h3,
        PR_DIR = 3'h4,
        PR_OD = 3'h5
    } gcgp_preg_e;
endpackage : gcgp_pkg

/* inc/gcgp_pin_if.sv */
`timescale 1ns/10ps
interface gcgp_pin_if;
    logic [7:0] wrData;
    logic [5:0] wrEn;
    logic levelRead;
    logic timerRoute;
    logic timerLevel;
    logic [7:0] pinIn;
    logic [7:0] pinOut;
    logic [7:0] pinOe;
    logic [7:0] levelRd;
    logic [47:0] regsRd;
    logic irq;
    modport ctrl (output wrData, wrEn, levelRead, timerRoute, timerLevel, pinIn,
                  input pinOut, pinOe, levelRd, regsRd, irq);
    modport grp (input wrData, wrEn, levelRead, timerRoute, timerLevel, pinIn,
                 output pinOut, pinOe, levelRd, regsRd, irq);
endinterface : gcgp_pin_if

/* src/gcgp_pin_group.sv */
`timescale 1ns/10ps
module gcgp_pin_group #(
    parameter bit HAS_TIMER = 1'b0
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Control side
    gcgp_pin_if.grp pif
);
    import gcgp_pkg::*;

    logic [7:0] inten_q, level_q, tri_q, inv_q, dir_q, od_q;
    logic [7:0] sampled_q, irqPend_q, pinOut_q, pinOe_q;
    logic [7:0] effDir, effInv, effInten, effTri, effOd, effLevel, inLvl, edgeHit;

    // ********************************************
    // Pin control registers
    // ********************************************
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            inten_q <= ZERO_RESET;
            level_q <= ZERO_RESET;
            tri_q <= ZERO_RESET;
            inv_q <= ZERO_RESET;
            dir_q <= DIR_RESET;
            od_q <= ZERO_RESET;
        end else begin
            if (pif.wrEn[PR_INTEN]) inten_q <= pif.wrData;
            if (pif.wrEn[PR_LEVEL]) level_q <= pif.wrData;
            if (pif.wrEn[PR_TRI]) tri_q <= pif.wrData;
            if (pif.wrEn[PR_INV]) inv_q <= pif.wrData;
            if (pif.wrEn[PR_DIR]) dir_q <= pif.wrData;
            if (pif.wrEn[PR_OD]) od_q <= pif.wrData;
        end
    end

    // Timer routing overrides pin 0 completely while active
    always_comb begin
        effDir = dir_q;
        effInv = inv_q;
        effInten = inten_q;
        effTri = tri_q;
        effOd = od_q;
        effLevel = level_q;
        if (HAS_TIMER && pif.timerRoute) begin
            effDir[0] = 1'b0;
            effInv[0] = 1'b0;
            effInten[0] = 1'b0;
            effTri[0] = 1'b0;
            effOd[0] = 1'b0;
            effLevel[0] = pif.timerLevel;
        end
    end

    assign inLvl = pif.pinIn ^ effInv;
    // Edge toward the active level chosen by level and inversion settings
    assign edgeHit = (inLvl & ~sampled_q & ~effLevel) | (~inLvl & sampled_q & effLevel);

    // ********************************************
    // Input sampling and pin interrupts
    // ********************************************
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sampled_q <= ZERO_RESET;
            irqPend_q <= ZERO_RESET;
        end else begin
            sampled_q <= inLvl;
            // A new edge wins over the clearing read
            irqPend_q <= (pif.levelRead ? ZERO_RESET : irqPend_q)
                | (edgeHit & effInten & effDir);
        end
    end

    // ********************************************
    // Pin drivers (enable low means driving)
    // ********************************************
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pinOut_q <= ZERO_RESET;
            pinOe_q <= DIR_RESET;
        end else begin
            pinOut_q <= effLevel;
            // Open drain floats a high; tri-state floats always
            pinOe_q <= effDir | effTri | (effOd & effLevel);
        end
    end

    assign pif.pinOut = pinOut_q;
    assign pif.pinOe = pinOe_q;
    assign pif.levelRd = (inLvl & effDir) | (level_q & ~effDir);
    assign pif.regsRd = {od_q, dir_q, inv_q, tri_q, pif.levelRd, inten_q};
    assign pif.irq = |irqPend_q;
endmodule : gcgp_pin_group

/* src/gcgp_global_regs.sv */
`timescale 1ns/10ps
// Operation
// - Broadcast bit set makes channel configuration writes reach all four channels.
// - Channel leaving sleep raises wake interrupt unless suppress bit is set.
// - Global disable bit blocks every interrupt toward the host.
// - Load-status bit reads 0 after good EEPROM load, 1 after failure.
// - Three write-only control bits drive EEPROM clock, select and data-in.
// - A read-only control bit returns the EEPROM data-out pin level.
// - Direction bit 1 means input, 0 output; all reset to 1.
// - Sixteen pins in two groups of six registers, bit n controls pin n.
// - Inversion bit set inverts the sampled input level.
// - Only enabled input pins raise interrupts; enables reset to 0.
// - Pin interrupts are edge detected, polarity from level and inversion.
// - Reading the level register clears pending pin interrupts.
// - All sixteen pin interrupts OR into channel 0 status.
// - Level writes drive outputs; reads return input pin levels, or the written level for output pins.
// - Tri-state bit set floats the output driver.
// - Open-drain bit drives only low; no effect on inputs.
// - Timer routed to pin 0 makes pin registers ignore pin 0.
// - Routed timer forces pin 0 to output, driving the timer level.
module gcgp_global_regs (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Register port
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regAddr,
    input wire logic [3:0] regBe,
    input wire logic [31:0] regWdata,
    output logic [31:0] regRdata,
    // Channel configuration write request
    input wire logic [3:0] chanCfgWrReq,
    output logic [3:0] chanCfgWrEn,
    // Interrupt sources and host request
    input wire logic [3:0] chanWake,
    input wire logic [3:0] chanIrq,
    input wire logic timerIrq,
    output logic hostIrq,
    output logic chan0PinIrq,
    // EEPROM load result and pins
    input wire logic loadDone,
    input wire logic loadFail,
    output logic eepromSerialClock,
    output logic eepromChipSelect,
    output logic eepromSerialIn,
    input wire logic eepromSerialOut,
    // Timer routing
    input wire logic timerRoute,
    input wire logic timerLevel,
    // General purpose pins
    input wire logic [15:0] pinIn,
    output logic [15:0] pinOut,
    output logic [15:0] pinOeN
);
    import gcgp_pkg::*;

    logic [2:0] ctrl_q;
    logic loadErr_q;
    logic eck_q, ecs_q, edi_q;
    logic [3:0] cfgWrEn_q;
    logic hostIrq_q, pinIrq_q, wakeIrq_q;
    logic [31:0] rdata_q;
    logic [GROUPS-1:0] grpIrq;
    logic [15:0] grpOut, grpOe;
    logic [7:0] ctrlByte;
    logic ctrlWr;

    gcgp_pin_if pif [GROUPS] ();

    function automatic logic [2:0] pinRegIdx(input logic [7:0] addr, input logic [7:0] base);
        logic [7:0] d;
        d = addr - base;
        pinRegIdx = d[2:0];
    endfunction : pinRegIdx

    function automatic logic inGroup(input logic [7:0] addr, input logic [7:0] base);
        inGroup = (addr >= base) && (addr < base + 8'h06);
    endfunction : inGroup

    // ********************************************
    // Pin groups
    // ********************************************
    // Pin registers are byte wide and addressed per byte; data on lane 0
    assign ctrlWr = regWr && (regAddr == ADDR_CFG_W1) && regBe[2];

    generate
        for (genvar g = 0; g < GROUPS; g++) begin : g_grp
            localparam logic [7:0] BASE = (g == 0) ? ADDR_PIN_LO : ADDR_PIN_HI;
            always_comb begin
                pif[g].wrData = regWdata[7:0];
                pif[g].wrEn = '0;
                if (regWr && regBe[0] && inGroup(regAddr, BASE)) begin
                    pif[g].wrEn[pinRegIdx(regAddr, BASE)] = 1'b1;
                end
            end
            assign pif[g].levelRead = regRd && (regAddr == BASE + 8'h01);
            assign pif[g].timerRoute = timerRoute;
            assign pif[g].timerLevel = timerLevel;
            assign pif[g].pinIn = pinIn[g*PINS +: PINS];
            assign grpOut[g*PINS +: PINS] = pif[g].pinOut;
            assign grpOe[g*PINS +: PINS] = pif[g].pinOe;
            assign grpIrq[g] = pif[g].irq;
            gcgp_pin_group #(.HAS_TIMER(g == 0)) u_grp (
                .core_clk(core_clk),
                .reset(reset),
                .pif(pif[g])
            );
        end
    endgenerate

    // ********************************************
    // Global control byte
    // ********************************************
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ctrl_q <= CTRL_RESET[2:0];
        end else if (ctrlWr) begin
            ctrl_q[CB_BCAST] <= regWdata[CTRL_LSB + CB_BCAST];
            ctrl_q[CB_WAKEOFF] <= regWdata[CTRL_LSB + CB_WAKEOFF];
            ctrl_q[CB_IRQOFF] <= regWdata[CTRL_LSB + CB_IRQOFF];
        end
    end

    // Write-only EEPROM pins hold until the next control write
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            eck_q <= 1'b0;
            ecs_q <= 1'b0;
            edi_q <= 1'b0;
        end else if (ctrlWr) begin
            eck_q <= regWdata[CTRL_LSB + CB_ECLK];
            ecs_q <= regWdata[CTRL_LSB + CB_ECS];
            edi_q <= regWdata[CTRL_LSB + CB_EDI];
        end
    end

    // Load status is zero until a load finishes; a failure sets it
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            loadErr_q <= 1'b0;
        end else if (loadDone) begin
            loadErr_q <= loadFail;
        end
    end

    // ********************************************
    // Broadcast configuration writes
    // ********************************************
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cfgWrEn_q <= 4'h0;
        end else begin
            cfgWrEn_q <= ctrl_q[CB_BCAST] && (|chanCfgWrReq) ? 4'hf : chanCfgWrReq;
        end
    end

    // ********************************************
    // Interrupt forwarding
    // ********************************************
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            wakeIrq_q <= 1'b0;
            pinIrq_q <= 1'b0;
            hostIrq_q <= 1'b0;
        end else begin
            wakeIrq_q <= (|chanWake) && !ctrl_q[CB_WAKEOFF];
            pinIrq_q <= |grpIrq;
            // Gate is registered, so a disable takes one cycle to reach the pin
            hostIrq_q <= !ctrl_q[CB_IRQOFF] && ((|chanIrq) || timerIrq || wakeIrq_q || pinIrq_q);
        end
    end

    // ********************************************
    // Read data and pin outputs
    // ********************************************
    assign ctrlByte = {eepromSerialOut, 3'h0, loadErr_q, ctrl_q};

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rdata_q <= '0;
        end else if (regRd) begin
            if (regAddr == ADDR_CFG_W1) begin
                rdata_q <= {8'h00, ctrlByte, 16'h0000};
            end else if (regAddr == ADDR_CFG_W0) begin
                rdata_q <= {24'h000000, REVISION_VALUE};
            end else if (inGroup(regAddr, ADDR_PIN_LO)) begin
                rdata_q <= {24'h000000, pif[0].regsRd[pinRegIdx(regAddr, ADDR_PIN_LO)*8 +: 8]};
            end else if (inGroup(regAddr, ADDR_PIN_HI)) begin
                rdata_q <= {24'h000000, pif[1].regsRd[pinRegIdx(regAddr, ADDR_PIN_HI)*8 +: 8]};
            end else begin
                rdata_q <= '0;
            end
        end
    end

    assign regRdata = rdata_q;
    assign chanCfgWrEn = cfgWrEn_q;
    assign hostIrq = hostIrq_q;
    assign chan0PinIrq = pinIrq_q;
    assign eepromSerialClock = eck_q;
    assign eepromChipSelect = ecs_q;
    assign eepromSerialIn = edi_q;
    assign pinOut = grpOut;
    assign pinOeN = grpOe;
endmodule : gcgp_global_regs

/* tb/gcgp_global_regs_props.sv */
`timescale 1ns/10ps
module gcgp_global_regs_props (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Register port
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regAddr,
    input wire logic [3:0] regBe,
    input wire logic [31:0] regWdata,
    input wire logic [31:0] regRdata,
    // Channels and interrupts
    input wire logic [3:0] chanCfgWrReq,
    input wire logic [3:0] chanCfgWrEn,
    input wire logic [3:0] chanWake,
    input wire logic [3:0] chanIrq,
    input wire logic hostIrq,
    // Serial memory and pins
    input wire logic eepromSerialClock,
    input wire logic eepromChipSelect,
    input wire logic eepromSerialIn,
    input wire logic eepromSerialOut,
    input wire logic timerRoute,
    input wire logic [15:0] pinOeN
);
    import gcgp_pkg::*;
    // ****
    // Shadow of the read-write control bits
    // ****
    logic ctrlWr;
    logic [2:0] ctrlQ;
    assign ctrlWr = regWr && regAddr == ADDR_CFG_W1 && regBe[2];
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ctrlQ <= 3'h0;
        end else if (ctrlWr) begin
            ctrlQ <= regWdata[18:16];
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    property p_bcast;
        chanCfgWrReq != 4'h0 |=> chanCfgWrEn == ($past(ctrlQ[CB_BCAST]) ? 4'hf : $past(chanCfgWrReq));
    endproperty
    a_bcast: assert property (p_bcast) else $error("channel write enables wrong");
    property p_ee_set;
        ctrlWr |=> {eepromSerialIn, eepromChipSelect, eepromSerialClock} == $past(regWdata[22:20]);
    endproperty
    a_ee_set: assert property (p_ee_set) else $error("serial memory pins not written");
    property p_ee_hold;
        !ctrlWr |=> $stable({eepromSerialIn, eepromChipSelect, eepromSerialClock});
    endproperty
    a_ee_hold: assert property (p_ee_hold) else $error("serial memory pins moved");
    property p_ee_read;
        regRd && regAddr == ADDR_CFG_W1 |=> regRdata[23] == $past(eepromSerialOut);
    endproperty
    a_ee_read: assert property (p_ee_read) else $error("data out bit wrong");
    property p_gate;
        ctrlQ[CB_IRQOFF] && $past(ctrlQ[CB_IRQOFF]) |-> !hostIrq;
    endproperty
    a_gate: assert property (p_gate) else $error("host interrupt not gated");
    property p_pass;
        !ctrlQ[CB_IRQOFF] && !ctrlWr && chanIrq != 4'h0 |=> hostIrq;
    endproperty
    a_pass: assert property (p_pass) else $error("host interrupt missing");
    property p_wake;
        !ctrlQ[CB_WAKEOFF] && !ctrlQ[CB_IRQOFF] && !ctrlWr && chanWake != 4'h0 |-> ##[1:2] hostIrq;
    endproperty
    a_wake: assert property (p_wake) else $error("wake interrupt missing");
    property p_timer;
        timerRoute && $past(timerRoute) && $past(timerRoute, 2) |-> !pinOeN[0];
    endproperty
    a_timer: assert property (p_timer) else $error("timer pin not driven");
endmodule : gcgp_global_regs_props

bind gcgp_global_regs gcgp_global_regs_props u_props (.core_clk, .reset, .regWr, .regRd, .regAddr, .regBe,
    .regWdata, .regRdata, .chanCfgWrReq, .chanCfgWrEn, .chanWake, .chanIrq, .hostIrq, .eepromSerialClock,
    .eepromChipSelect, .eepromSerialIn, .eepromSerialOut, .timerRoute, .pinOeN);

/* tb/gcgp_far_side.sv */
`timescale 1ns/10ps
module gcgp_far_side (
    // Block pin drivers
    input wire logic [15:0] pinOut,
    input wire logic [15:0] pinOeN,
    // Outside loads
    input wire logic [15:0] extLevel,
    input wire logic [15:0] extDrive,
    output logic [15:0] pinIn,
    // Serial memory
    input wire logic eepromSerialClock,
    input wire logic eepromChipSelect,
    input wire logic eepromSerialIn,
    output logic eepromSerialOut
);
    logic dataQ;
    // Undriven pins float up through board pull-ups
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            pinIn[i] = !pinOeN[i] ? pinOut[i] : (extDrive[i] ? extLevel[i] : 1'b1);
        end
    end
    initial dataQ = 1'b0;
    always @(posedge eepromSerialClock) begin
        if (eepromChipSelect) begin
            dataQ <= eepromSerialIn;
        end
    end
    // Deselected output shows the inverse so a stale level never passes by chance
    assign eepromSerialOut = eepromChipSelect ? dataQ : !dataQ;
endmodule : gcgp_far_side

/* tb/global_config_gpio_eeprom_regs_test.sv */
`timescale 1ns/10ps
module global_config_gpio_eeprom_regs_test;
    import gcgp_pkg::*;
    logic core_clk, reset, regWr, regRd, timerIrq, hostIrq, chan0PinIrq, loadDone, loadFail;
    logic eepromSerialClock, eepromChipSelect, eepromSerialIn, eepromSerialOut, timerRoute, timerLevel;
    logic [7:0] regAddr;
    logic [3:0] regBe, chanCfgWrReq, chanCfgWrEn, chanWake, chanIrq;
    logic [31:0] regWdata, regRdata, rdv;
    logic [15:0] pinIn, pinOut, pinOeN, extLevel, extDrive;
    int n_errors, n_checks;
    gcgp_global_regs dut (.core_clk, .reset, .regWr, .regRd, .regAddr, .regBe, .regWdata, .regRdata,
        .chanCfgWrReq, .chanCfgWrEn, .chanWake, .chanIrq, .timerIrq, .hostIrq, .chan0PinIrq, .loadDone,
        .loadFail, .eepromSerialClock, .eepromChipSelect, .eepromSerialIn, .eepromSerialOut, .timerRoute,
        .timerLevel, .pinIn, .pinOut, .pinOeN);
    gcgp_far_side u_far (.pinOut, .pinOeN, .extLevel, .extDrive, .pinIn, .eepromSerialClock,
        .eepromChipSelect, .eepromSerialIn, .eepromSerialOut);
    // ****
    // Bus and check helpers
    // ****
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask : cyc
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // Trailing idle cycle keeps strobes from being reassigned in one time step
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        {regAddr, regBe, regWdata, regWr} = {a, be, d, 1'b1};
        cyc(1);
        regWr = 1'b0;
        cyc(1);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        {regAddr, regBe, regRd} = {a, 4'hf, 1'b1};
        cyc(1);
        regRd = 1'b0;
        d = regRdata;
        cyc(1);
    endtask : rd
    function automatic logic [7:0] pa(input int g, input gcgp_preg_e r);
        return ADDR_PIN_LO + 8'(6 * g) + 8'(r);
    endfunction : pa
    task automatic give_verdict;
        $display("Checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict
    // ****
    // Scenarios
    // ****
    task automatic t_reset;
        chk("pin enables", 32'hffff, {16'h0, pinOeN});
        chk("serial pins", 32'h0, {29'h0, eepromSerialIn, eepromChipSelect, eepromSerialClock});
        rd(ADDR_CFG_W0, rdv);
        chk("revision", {24'h0, REVISION_VALUE}, {24'h0, rdv[7:0]});
        rd(ADDR_CFG_W1, rdv);
        chk("control reset", 32'h0, {29'h0, rdv[18:16]});
        for (int g = 0; g < GROUPS; g++) begin
            for (int r = 0; r < 6; r++) begin
                rd(pa(g, gcgp_preg_e'(r)), rdv);
                chk("pin reg reset", (r == int'(PR_DIR)) ? 32'hff : 32'h0, {24'h0, rdv[7:0]});
            end
        end
        rd(8'ha0, rdv);
        chk("unmapped read", 32'h0, rdv);
    endtask : t_reset
    task automatic t_bcast;
        for (int b = 0; b < 2; b++) begin
            wr(ADDR_CFG_W1, 4'h4, 32'(b) << (CTRL_LSB + CB_BCAST));
            chanCfgWrReq = 4'h2;
            cyc(1);
            chanCfgWrReq = 4'h0;
            chk("config enables", b ? 32'hf : 32'h2, {28'h0, chanCfgWrEn});
        end
    endtask : t_bcast
    task automatic t_irq;
        chanIrq = 4'h8;
        wr(ADDR_CFG_W1, 4'h4, 32'h0);
        chk("host irq", 32'h1, {31'h0, hostIrq});
        wr(ADDR_CFG_W1, 4'h4, 32'h1 << (CTRL_LSB + CB_IRQOFF));
        cyc(1);
        chk("host irq gated", 32'h0, {31'h0, hostIrq});
        chanIrq = 4'h0;
        wr(ADDR_CFG_W1, 4'h4, 32'h1 << (CTRL_LSB + CB_WAKEOFF));
        chanWake = 4'h4;
        cyc(1);
        chanWake = 4'h0;
        cyc(1);
        chk("wake suppressed", 32'h0, {31'h0, hostIrq});
        wr(ADDR_CFG_W1, 4'h4, 32'h0);
        chanWake = 4'h1;
        cyc(1);
        chanWake = 4'h0;
        cyc(1);
        chk("wake irq", 32'h1, {31'h0, hostIrq});
        timerIrq = 1'b1;
        cyc(1);
        chk("timer irq", 32'h1, {31'h0, hostIrq});
        timerIrq = 1'b0;
    endtask : t_irq
    task automatic t_eeprom;
        for (int v = 0; v < 8; v++) begin
            wr(ADDR_CFG_W1, 4'h4, 32'(v) << (CTRL_LSB + CB_ECLK));
            chk("serial pins", 32'(v), {29'h0, eepromSerialIn, eepromChipSelect, eepromSerialClock});
        end
        wr(pa(0, PR_INTEN), 4'h1, 32'h0);
        chk("serial hold", 32'h7, {29'h0, eepromSerialIn, eepromChipSelect, eepromSerialClock});
        rd(ADDR_CFG_W1, rdv);
        chk("data out", 32'h1, {31'h0, rdv[CTRL_LSB + CB_EDO]});
        // Deselected memory shows the inverse of its last bit
        wr(ADDR_CFG_W1, 4'h4, 32'h0);
        rd(ADDR_CFG_W1, rdv);
        chk("data out deselected", 32'h0, {31'h0, rdv[CTRL_LSB + CB_EDO]});
        for (int f = 1; f >= 0; f--) begin
            {loadFail, loadDone} = {f[0], 1'b1};
            cyc(1);
            loadDone = 1'b0;
            rd(ADDR_CFG_W1, rdv);
            chk("load status", 32'(f), {31'h0, rdv[CTRL_LSB + CB_LOADERR]});
        end
    endtask : t_eeprom
    task automatic t_outputs;
        extDrive = 16'h0;
        for (int g = 0; g < GROUPS; g++) begin
            wr(pa(g, PR_DIR), 4'h1, 32'h0);
            wr(pa(g, PR_LEVEL), 4'h1, 32'ha5);
            chk("pin drive", 32'h00a5, {16'h0, pinOeN[8 * g +: 8], pinOut[8 * g +: 8]});
            wr(pa(g, PR_TRI), 4'h1, 32'h0f);
            wr(pa(g, PR_OD), 4'h1, 32'hff);
            chk("pin float", 32'hafaf, {16'h0, pinOeN[8 * g +: 8], pinIn[8 * g +: 8]});
            wr(pa(g, PR_TRI), 4'h1, 32'h0);
            wr(pa(g, PR_OD), 4'h1, 32'h0);
            wr(pa(g, PR_DIR), 4'h1, 32'hff);
            wr(pa(g, PR_LEVEL), 4'h1, 32'h0);
        end
        extDrive = 16'hffff;
    endtask : t_outputs
    task automatic t_inputs;
        extLevel = 16'h003c;
        wr(pa(0, PR_INV), 4'h1, 32'h0f);
        rd(pa(0, PR_LEVEL), rdv);
        chk("inverted level", 32'h33, {24'h0, rdv[7:0]});
        wr(pa(0, PR_INV), 4'h1, 32'h0);
        wr(pa(0, PR_INTEN), 4'h1, 32'h02);
        rd(pa(0, PR_LEVEL), rdv);
        for (int k = 0; k < 2; k++) begin
            extLevel = k ? 16'h003c : 16'h003e;
            for (int i = 0; i < 8 && chan0PinIrq !== 1'b1; i++) @(negedge core_clk);
            chk("pin irq", 32'h1, {31'h0, chan0PinIrq});
            cyc(1);
            chk("host pin irq", 32'h1, {31'h0, hostIrq});
            rd(pa(0, PR_LEVEL), rdv);
            cyc(1);
            chk("pin irq cleared", 32'h0, {31'h0, chan0PinIrq});
            wr(pa(0, PR_LEVEL), 4'h1, 32'h02);
            rd(pa(0, PR_LEVEL), rdv);
        end
        // Inversion lets the driven level make edges of the active polarity
        wr(pa(0, PR_INV), 4'h1, 32'h02);
        wr(pa(0, PR_DIR), 4'h1, 32'hfd);
        wr(pa(0, PR_LEVEL), 4'h1, 32'h0);
        cyc(3);
        chk("output pin irq", 32'h0, {31'h0, chan0PinIrq});
        wr(pa(0, PR_DIR), 4'h1, 32'hff);
        wr(pa(0, PR_INTEN), 4'h1, 32'h0);
        wr(pa(0, PR_INV), 4'h1, 32'h0);
    endtask : t_inputs
    task automatic t_timer;
        {timerLevel, timerRoute} = 2'h3;
        cyc(3);
        chk("timer pin", 32'h1, {30'h0, pinOeN[0], pinOut[0]});
        wr(pa(0, PR_TRI), 4'h1, 32'h01);
        chk("timer pin kept", 32'h1, {30'h0, pinOeN[0], pinOut[0]});
        timerRoute = 1'b0;
        cyc(3);
        chk("pin released", 32'h1, {31'h0, pinOeN[0]});
    endtask : t_timer
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        give_verdict();
    end
    initial begin
        {regWr, regRd, timerIrq, loadDone, loadFail, timerRoute, timerLevel} = '0;
        {regAddr, regBe, regWdata, chanCfgWrReq, chanWake, chanIrq, extLevel} = '0;
        extDrive = 16'hffff;
        reset = 1'b1;
        cyc(10);
        reset = 1'b0;
        cyc(1);
        t_reset();
        t_bcast();
        t_irq();
        t_eeprom();
        t_outputs();
        t_inputs();
        t_timer();
        give_verdict();
    end
endmodule : global_config_gpio_eeprom_regs_test
